// file: hw/sc3_ctrl_data.sv
// Control register three and the data port of the asynchronous serial port.
// Assumes the shifters, baud logic and flags live outside on the same clock;
// the line pins arrive already synchronised by the pad logic.
// How it works
// - Received ninth bit readable at control bit 7
// - Control bit 6 is ninth transmit bit
// - Full nine bits handed over on data write
// - Transmit ninth bit kept across frames
// - Single-wire mode: bit 5 set drives pin
// - Bit 4 inverts every transmitted level
// - Overrun flag raises request when enabled
// - Noise flag raises request when enabled
// - Framing flag raises request when enabled
// - Parity flag raises request when enabled
// - Data port: read receive, write transmit
// - Data accesses step flag-clearing sequences
// - Decoded at both global base addresses
// - Noise clears after status read then data read
// - Frame: start 0, LSB first, stop 1
`timescale 1ns/1ps
module sc3_ctrl_data
    import sc3_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [11:0] reg_addr,
    input  wire logic        reg_rd,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic        rx_load,
    input  wire logic [7:0]  rx_byte,
    input  wire logic        rx_bit8,
    input  wire logic        overrun_flag,
    input  wire logic        noise_flag,
    input  wire logic        framing_fault_flag,
    input  wire logic        parity_fault_flag,
    input  wire logic        loopback_sel,
    input  wire logic        rx_source_sel,
    input  wire logic        tx_line_raw,
    output logic      [8:0]  tx_word,
    output logic             tx_word_load,
    output logic             data_rd_strobe,
    output logic             data_wr_strobe,
    output logic             status_rd_strobe,
    output logic             tx_pin_o,
    output logic             tx_pin_oe,
    output logic             err_irq
);
    typedef struct packed {
        logic [7:0] ctrl3;
        logic [7:0] rxbuf;
        logic [8:0] txbuf;
        logic       txload;
        logic [7:0] rdata;
    } sc3_state_s;

    sc3_state_s st_q;
    sc3_state_s st_d;

    logic [7:0] off;
    logic       hit;
    logic       sel_c3;
    logic       sel_dp;
    logic       sel_s1;

    // ==================================================================
    // Address decode
    always_comb begin
        off = reg_addr[7:0];
        hit = (reg_addr[11:8] == SC3_BASE_BLOCK[11:8])
            || (reg_addr[11:8] == SC3_BASE_NONBLOCK[11:8]);
        sel_c3 = hit && (off == SC3_OFF_CTRL3);
        sel_dp = hit && (off == SC3_OFF_DATA);
        sel_s1 = hit && (off == SC3_OFF_STAT1);
    end

    // ==================================================================
    // State update
    always_comb begin
        st_d = st_q;
        st_d.txload = 1'b0;
        if (rx_load) begin
            st_d.rxbuf = rx_byte;
            st_d.ctrl3[SC3_B_RX9] = rx_bit8;
        end
        // Ninth bit only changes on a control write, so it is reused
        if (reg_wr && sel_c3) begin
            st_d.ctrl3 = (reg_wdata & SC3_CTRL3_WMASK)
                | (st_d.ctrl3 & ~SC3_CTRL3_WMASK);
        end
        if (reg_wr && sel_dp) begin
            st_d.txbuf = {st_d.ctrl3[SC3_B_TX9], reg_wdata};
            st_d.txload = 1'b1;
        end
        if (reg_rd && sel_c3) begin
            st_d.rdata = st_q.ctrl3;
        end else if (reg_rd && sel_dp) begin
            st_d.rdata = st_q.rxbuf;
        end else if (reg_rd) begin
            st_d.rdata = 8'h00;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '{ctrl3: SC3_CTRL3_RST, rxbuf: SC3_DATA_RST,
                       txbuf: {SC3_CTRL3_RST[SC3_B_TX9], SC3_DATA_RST},
                       txload: 1'b0,
                       rdata: SC3_DATA_RST};
        end else begin
            st_q <= st_d;
        end
    end

    // ==================================================================
    // Outputs
    logic single_wire;
    assign single_wire      = loopback_sel && rx_source_sel;
    assign reg_rdata        = st_q.rdata;
    assign tx_word          = st_q.txbuf;
    assign tx_word_load     = st_q.txload;
    // Flag logic outside completes its clear sequences on these
    assign data_rd_strobe   = reg_rd && sel_dp;
    assign data_wr_strobe   = reg_wr && sel_dp;
    assign status_rd_strobe = reg_rd && sel_s1;
    // Idle, start, data and stop all flip together with polarity
    assign tx_pin_o  = tx_line_raw ^ st_q.ctrl3[SC3_B_INV];
    assign tx_pin_oe = single_wire ? st_q.ctrl3[SC3_B_DIR] : 1'b1;
    // Enables sit in the same bit order as the flags, so one loop keeps
    // the flag-to-enable pairing in a single place
    logic [3:0] err_flags;
    logic [3:0] err_req;
    assign err_flags = {overrun_flag, noise_flag,
                        framing_fault_flag, parity_fault_flag};
    for (genvar i = 0; i < 4; i++) begin : g_err_req
        assign err_req[i] = err_flags[i]
            && st_q.ctrl3[SC3_B_PARITY_IRQ_EN + i];
    end
    // Flags are levels, so the request stays up while the flag and its enable are both set
    assign err_irq = |err_req;

    // ==================================================================
    // Checks: register access and transmit hand-over
    a_tx_word_load: assert property (@(posedge clk)
        disable iff (!resetn)
        (reg_wr && sel_dp) |=> tx_word_load
            && tx_word == {$past(st_d.ctrl3[SC3_B_TX9]), $past(reg_wdata)})
        else $error("transmit word not loaded");
    a_load_pulse: assert property (@(posedge clk)
        disable iff (!resetn)
        !(reg_wr && sel_dp) |=> !tx_word_load)
        else $error("transmit load without data write");
    a_tx_word_hold: assert property (@(posedge clk)
        disable iff (!resetn)
        !(reg_wr && sel_dp) |=> $stable(tx_word))
        else $error("transmit word changed without write");
    a_tx9_kept: assert property (@(posedge clk)
        disable iff (!resetn)
        !(reg_wr && sel_c3) |=> $stable(st_q.ctrl3[SC3_B_TX9]))
        else $error("ninth transmit bit changed");
    a_ctrl_write: assert property (@(posedge clk)
        disable iff (!resetn)
        (reg_wr && sel_c3) |=>
            st_q.ctrl3[SC3_B_TX9:0] == $past(reg_wdata[SC3_B_TX9:0]))
        else $error("control write did not land");
    a_rx9_capture: assert property (@(posedge clk)
        disable iff (!resetn)
        rx_load |=> st_q.ctrl3[SC3_B_RX9] == $past(rx_bit8))
        else $error("ninth receive bit wrong");
    a_rx9_readonly: assert property (@(posedge clk)
        disable iff (!resetn)
        (reg_wr && sel_c3 && !rx_load) |=>
            $stable(st_q.ctrl3[SC3_B_RX9]))
        else $error("receive ninth bit written");
    a_rxbuf_hold: assert property (@(posedge clk)
        disable iff (!resetn)
        !rx_load |=> $stable(st_q.rxbuf))
        else $error("receive buffer changed without load");
    a_rd_data: assert property (@(posedge clk)
        disable iff (!resetn)
        (reg_rd && sel_dp) |=> reg_rdata == $past(st_q.rxbuf))
        else $error("data read wrong");
    a_rdata_hold: assert property (@(posedge clk)
        disable iff (!resetn)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without read");
    a_unmapped_rd: assert property (@(posedge clk)
        disable iff (!resetn)
        (reg_rd && !sel_c3 && !sel_dp) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_status_strobe: assert property (@(posedge clk)
        disable iff (!resetn)
        status_rd_strobe |-> (reg_rd && !data_rd_strobe))
        else $error("status strobe without status read");

    // ==================================================================
    // Checks: line pin and error requests
    a_inv_out: assert property (@(posedge clk)
        disable iff (!resetn)
        st_q.ctrl3[SC3_B_INV] |-> tx_pin_o != tx_line_raw)
        else $error("transmit not inverted");
    a_inv_clear: assert property (@(posedge clk)
        disable iff (!resetn)
        !st_q.ctrl3[SC3_B_INV] |-> tx_pin_o == tx_line_raw)
        else $error("transmit inverted while disabled");
    a_dir_single: assert property (@(posedge clk)
        disable iff (!resetn)
        single_wire |-> tx_pin_oe == st_q.ctrl3[SC3_B_DIR])
        else $error("single-wire direction wrong");
    a_oe_normal: assert property (@(posedge clk)
        disable iff (!resetn)
        !single_wire |-> tx_pin_oe)
        else $error("pin not driven outside single-wire");
    a_ovr_irq: assert property (@(posedge clk)
        disable iff (!resetn)
        (overrun_flag && st_q.ctrl3[SC3_B_OVERRUN_IRQ_EN]) |-> err_irq)
        else $error("overrun request missing");
    a_noise_irq: assert property (@(posedge clk)
        disable iff (!resetn)
        (noise_flag && st_q.ctrl3[SC3_B_NOISE_IRQ_EN]) |-> err_irq)
        else $error("noise request missing");
    a_frame_irq: assert property (@(posedge clk)
        disable iff (!resetn)
        (framing_fault_flag && st_q.ctrl3[SC3_B_FRAMING_IRQ_EN]) |-> err_irq)
        else $error("framing request missing");
    a_parity_irq: assert property (@(posedge clk)
        disable iff (!resetn)
        (parity_fault_flag && st_q.ctrl3[SC3_B_PARITY_IRQ_EN]) |-> err_irq)
        else $error("parity request missing");
    a_irq_quiet: assert property (@(posedge clk)
        disable iff (!resetn)
        (st_q.ctrl3[SC3_B_OVERRUN_IRQ_EN:SC3_B_PARITY_IRQ_EN] == 4'h0) |-> !err_irq)
        else $error("request while disabled");
    a_irq_combined: assert property (@(posedge clk)
        disable iff (!resetn)
        err_irq |->
            (err_flags & st_q.ctrl3[SC3_B_OVERRUN_IRQ_EN:SC3_B_PARITY_IRQ_EN]) != 4'h0)
        else $error("request without enabled flag");
endmodule : sc3_ctrl_data

// file: pkg/sc3_pkg.sv
// Constants for the serial port control-three and data-port block.
// Assumes a single clock domain and an 8-bit register access port.
package sc3_pkg;
    // ==================================================================
    // Address map
    localparam logic [11:0] SC3_BASE_BLOCK    = 12'h200;
    localparam logic [11:0] SC3_BASE_NONBLOCK = 12'h300;
    localparam logic [7:0]  SC3_OFF_CTRL3     = 8'h46;
    localparam logic [7:0]  SC3_OFF_DATA      = 8'h47;
    localparam logic [7:0]  SC3_OFF_STAT1     = 8'h44;
    // ==================================================================
    // Control-three field positions
    localparam int SC3_B_RX9  = 7;
    localparam int SC3_B_TX9  = 6;
    localparam int SC3_B_DIR  = 5;
    localparam int SC3_B_INV  = 4;
    localparam int SC3_B_OVERRUN_IRQ_EN = 3;
    localparam int SC3_B_NOISE_IRQ_EN = 2;
    localparam int SC3_B_FRAMING_IRQ_EN = 1;
    localparam int SC3_B_PARITY_IRQ_EN = 0;
    // Writable bits of control three (receive ninth bit is read-only)
    localparam logic [7:0] SC3_CTRL3_WMASK = 8'h7f;
    // ==================================================================
    // Reset values
    localparam logic [7:0] SC3_CTRL3_RST = 8'h00;
    localparam logic [7:0] SC3_DATA_RST  = 8'h00;
endpackage : sc3_pkg

// file: verification/sc3_far_end.sv
// Far-end receiver model: hands one received word to the port.
// Assumes the bench pulses send for one clock cycle.
`timescale 1ns/1ps
module sc3_far_end (
    input  wire logic       clk,
    input  wire logic       send,
    input  wire logic [8:0] word,
    output logic            rx_load,
    output logic [7:0]      rx_byte,
    output logic            rx_bit8
);
    // ==========
    // Hand-over
    always_ff @(posedge clk) begin
        rx_load <= send;
        // Stale lines toggle so a late sample cannot pass by luck
        rx_byte <= send ? word[7:0] : ~rx_byte;
        rx_bit8 <= send ? word[8] : ~rx_bit8;
    end
endmodule : sc3_far_end

// file: verification/serial_ctrl3_data_port_bench.sv
// Bench for the control-three and data-port block.
// Assumes the far-end model supplies received words.
`timescale 1ns/1ps
module serial_ctrl3_data_port_bench;
    logic clk = 0, resetn = 0, rd = 0, wr = 0, send = 0, raw = 1;
    logic lsel = 0, rsel = 0, ld, oe, po, irq, rxl, rx8, drs, dws, srs;
    logic [11:0] addr = 0;
    logic [7:0] wd = 0, rdata, rxb;
    logic [8:0] word = 0, txw;
    logic [3:0] fl = 0;
    int error_cnt = 0, n_checks = 0;
    always #5 clk = ~clk;
    sc3_far_end u_sc3_far_end (.clk, .send, .word, .rx_load(rxl),
        .rx_byte(rxb), .rx_bit8(rx8));
    sc3_ctrl_data u_sc3_ctrl_data (.clk, .resetn, .reg_addr(addr),
        .reg_rd(rd), .reg_wr(wr), .reg_wdata(wd), .reg_rdata(rdata),
        .rx_load(rxl), .rx_byte(rxb), .rx_bit8(rx8),
        .overrun_flag(fl[3]), .noise_flag(fl[2]),
        .framing_fault_flag(fl[1]), .parity_fault_flag(fl[0]),
        .loopback_sel(lsel), .rx_source_sel(rsel), .tx_line_raw(raw),
        .tx_word(txw), .tx_word_load(ld), .data_rd_strobe(drs),
        .data_wr_strobe(dws), .status_rd_strobe(srs), .tx_pin_o(po),
        .tx_pin_oe(oe), .err_irq(irq));
    // ==========
    // Shared tasks
    task automatic chk(input logic [8:0] s, input logic [8:0] e);
        n_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %0t seen %h exp %h", $time, s, e);
        end
    endtask : chk
    task automatic acc(input logic [11:0] a, input logic [7:0] d,
                       input logic w);
        @(posedge clk) #1;
        addr = a;
        wd = d;
        wr = w;
        rd = !w;
        @(posedge clk) #1;
        wr = 0;
        rd = 0;
        if (!w) chk({1'b0, rdata}, {1'b0, d});
    endtask : acc
    task automatic wrap_up;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    // ==========
    // Scenarios
    task automatic t_rx;
        acc(12'h246, 8'h00, 0);
        acc(12'h347, 8'h00, 0);
        @(posedge clk) #1;
        word = 9'h15a;
        send = 1;
        @(posedge clk) #1;
        send = 0;
        acc(12'h246, 8'h80, 0);
        acc(12'h347, 8'h5a, 0);
    endtask : t_rx
    task automatic t_tx;
        acc(12'h246, 8'h7f, 1);
        acc(12'h246, 8'hff, 0);
        acc(12'h247, 8'ha5, 1);
        chk({ld, 8'h00}, 9'h100);
        chk(txw, 9'h1a5);
        @(posedge clk) #1 chk({ld, 8'h00}, 9'h000);
        chk(txw, 9'h1a5);
        acc(12'h347, 8'h3c, 1);
        chk(txw, 9'h13c);
    endtask : t_tx
    task automatic t_pin;
        lsel = 1;
        rsel = 1;
        acc(12'h246, 8'h30, 1);
        chk({7'h0, po, oe}, 9'h001);
        raw = 0;
        @(negedge clk) chk({7'h0, po, oe}, 9'h003);
        acc(12'h246, 8'h00, 1);
        chk({7'h0, po, oe}, 9'h000);
        raw = 1;
        @(negedge clk) chk({7'h0, po, oe}, 9'h002);
        @(posedge clk) #1 lsel = 0;
        @(negedge clk) chk({7'h0, po, oe}, 9'h003);
    endtask : t_pin
    task automatic t_irq;
        for (int i = 0; i < 4; i++) begin
            acc(12'h246, 8'h01 << i, 1);
            fl = ~(4'h1 << i);
            @(negedge clk) chk({8'h0, irq}, 9'h000);
            @(posedge clk) #1 fl = 4'h1 << i;
            @(negedge clk) chk({8'h0, irq}, 9'h001);
            @(posedge clk) #1 fl = 4'h0;
        end
        acc(12'h246, 8'h00, 1);
        fl = 4'hf;
        @(negedge clk) chk({8'h0, irq}, 9'h000);
        @(posedge clk) #1 fl = 4'h0;
        acc(12'h146, 8'h00, 0);
    endtask : t_irq
    task automatic t_clear;
        @(posedge clk) #1;
        addr = 12'h244;
        rd = 1;
        @(negedge clk) chk({6'h0, srs, drs, dws}, 9'h004);
        @(posedge clk) #1;
        chk({1'b0, rdata}, 9'h000);
        addr = 12'h347;
        @(negedge clk) chk({6'h0, srs, drs, dws}, 9'h002);
        @(posedge clk) #1;
        chk({1'b0, rdata}, 9'h05a);
        addr = 12'h247;
        rd = 0;
        wr = 1;
        wd = 8'h11;
        @(negedge clk) chk({6'h0, srs, drs, dws}, 9'h001);
        @(posedge clk) #1;
        wr = 0;
        chk({ld, 8'h00}, 9'h100);
        chk(txw, 9'h011);
        @(negedge clk) chk({6'h0, srs, drs, dws}, 9'h000);
    endtask : t_clear
    task automatic t_reset;
        acc(12'h346, 8'h7f, 1);
        @(posedge clk) #1 resetn = 0;
        @(negedge clk) chk(txw, 9'h000);
        chk({ld, rdata}, 9'h000);
        chk({7'h0, oe, irq}, 9'h002);
        repeat (2) @(posedge clk);
        #1 resetn = 1;
        acc(12'h346, 8'h00, 0);
        acc(12'h347, 8'h00, 0);
        acc(12'h346, 8'hc0, 1);
        acc(12'h246, 8'h40, 0);
    endtask : t_reset
    initial begin
        #100000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        repeat (10) @(posedge clk);
        #1 resetn = 1;
        t_rx();
        t_tx();
        t_pin();
        t_irq();
        t_clear();
        t_reset();
        wrap_up();
    end
endmodule : serial_ctrl3_data_port_bench
